//--- rtl/lfao_pkg.sv
/*
 * lfao_pkg: shared constants and carrier types for the lane FIFO alarm
 * and core offset trim register bank.
 * assumes a 12-bit register address space and 16-bit register data.
 */
package lfao_pkg;

	// register port widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;

	// lane and trim geometry
	localparam int LANES     = 8;
	localparam int TRIM_W    = 12;
	localparam int TRIM_REGS = 4;

	// register offsets
	localparam logic [11:0] LANE_FLAGS_ADDR  = 12'h2C4;
	localparam logic [11:0] SUMMARY_ADDR     = 12'h2C0;
	localparam logic [11:0] CORE0_TRIM_ADDR  = 12'h330;
	localparam logic [11:0] CORE1_TRIM_ADDR  = 12'h332;
	localparam logic [11:0] CORE2A_TRIM_ADDR = 12'h334;
	localparam logic [11:0] CORE2B_TRIM_ADDR = 12'h336;
	localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h2D0;
	localparam logic [11:0] IRQ_MASK_ADDR    = 12'h2D2;

	// trim register index within the trim array
	localparam int TRIM_CORE0  = 0;
	localparam int TRIM_CORE1  = 1;
	localparam int TRIM_CORE2A = 2;
	localparam int TRIM_CORE2B = 3;

	// field positions
	localparam int SUMMARY_BIT   = 5;
	localparam int IRQ_FIFO_BIT  = 0;
	localparam int IRQ_GUARD_BIT = 1;
	localparam int IRQ_W         = 2;

	// reset values
	localparam logic [7:0]  LANE_FLAGS_RST = 8'hFF;
	localparam logic        SUMMARY_RST    = 1'b1;
	localparam logic [15:0] TRIM_RST       = 16'h0000;
	localparam logic [1:0]  IRQ_STATUS_RST = 2'h0;
	localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;

	// register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} lfao_req_t;

	// calibration engine status seen by the bank
	typedef struct packed {
		logic offset_cal_en;
		logic background_cal_en;
		logic continuous_bg_offset_cal_en;
		logic foreground_cal_done;
		logic cal_busy;
	} lfao_cal_t;

	// one 12-bit trim per trim register
	typedef logic [3:0][11:0] lfao_trim_set_t;

endpackage : lfao_pkg

//--- rtl/lfao_regs.sv
/*
 * lfao_regs: lane FIFO error flags, their summary bit, per-core offset
 * trim registers loaded from fuse storage, and an interrupt pair.
 * assumes all inputs synchronous to clk; fuse_load is a one-cycle pulse
 * issued by the fuse reader once its data are valid.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module lfao_regs (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// register port
	input  wire lfao_pkg::lfao_req_t     req,
	output logic [15:0]                  rdata_reg,
	// lane FIFO status
	input  wire logic [7:0]              lane_fifo_fault,
	input  wire logic [7:0]              lane_active,
	// calibration engine
	input  wire lfao_pkg::lfao_cal_t     cal,
	// fuse storage
	input  wire logic                    fuse_load,
	input  wire lfao_pkg::lfao_trim_set_t fuse_trim,
	// core two input choice, 1 = input b
	input  wire logic                    core2_input_b_sel,
	// trims applied to the cores
	output logic [11:0]                  core0_trim_reg,
	output logic [11:0]                  core1_trim_reg,
	output logic [11:0]                  core2_trim_reg,
	// alarm and interrupt
	output logic                         fifo_error_summary_reg,
	output logic                         irq_reg
);

	logic [7:0]                     lane_fifo_error_flags_reg;
	logic [7:0]                     lane_fifo_error_flags_next;
	logic [7:0]                     lane_clear;
	logic                           summary_next;
	logic                           summary_set;
	logic [15:0]                    trim_reg [lfao_pkg::TRIM_REGS];
	logic [3:0]                     trim_hit;
	logic                           trim_access;
	logic                           trim_guard;
	logic [1:0]                     irq_status_reg;
	logic [1:0]                     irq_mask_reg;
	logic [1:0]                     irq_event;
	logic [1:0]                     irq_clear;
	logic [15:0]                    rdata_next;

	// write decode for the alarm registers
	always_comb begin
		lane_clear = 8'h00;
		if (req.wr && req.addr == lfao_pkg::LANE_FLAGS_ADDR) begin
			lane_clear = req.wdata[7:0];
		end
		if (req.wr && req.addr == lfao_pkg::SUMMARY_ADDR
			&& req.wdata[lfao_pkg::SUMMARY_BIT]) begin
			lane_clear = 8'hFF;
		end
	end

	// faults are ORed in after the clear, so a set always wins
	assign lane_fifo_error_flags_next =
		(lane_fifo_error_flags_reg & ~lane_clear) | lane_fifo_fault;

	// summary follows active lanes only
	assign summary_set  = |(lane_fifo_fault & lane_active);
	assign summary_next = (fifo_error_summary_reg & ~(req.wr
		&& req.addr == lfao_pkg::SUMMARY_ADDR
		&& req.wdata[lfao_pkg::SUMMARY_BIT])) | summary_set;

	// lane error flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lane_fifo_error_flags_reg <= lfao_pkg::LANE_FLAGS_RST;
		end else begin
			lane_fifo_error_flags_reg <= lane_fifo_error_flags_next;
		end
	end

	// summary alarm bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fifo_error_summary_reg <= lfao_pkg::SUMMARY_RST;
		end else begin
			fifo_error_summary_reg <= summary_next;
		end
	end

	// trim address hits
	assign trim_hit[lfao_pkg::TRIM_CORE0]  = req.addr == lfao_pkg::CORE0_TRIM_ADDR;
	assign trim_hit[lfao_pkg::TRIM_CORE1]  = req.addr == lfao_pkg::CORE1_TRIM_ADDR;
	assign trim_hit[lfao_pkg::TRIM_CORE2A] = req.addr == lfao_pkg::CORE2A_TRIM_ADDR;
	assign trim_hit[lfao_pkg::TRIM_CORE2B] = req.addr == lfao_pkg::CORE2B_TRIM_ADDR;
	assign trim_access = (req.wr || req.rd) && (|trim_hit);

	// windows in which the host must keep off the trims
	always_comb begin
		trim_guard = cal.cal_busy;
		if (cal.background_cal_en && cal.continuous_bg_offset_cal_en) begin
			trim_guard = 1'b1;
		end else if (cal.offset_cal_en && !cal.foreground_cal_done) begin
			trim_guard = 1'b1;
		end
	end

	// trim registers: fuse defaults, host writes blocked inside a guard window
	for (genvar g = 0; g < lfao_pkg::TRIM_REGS; g++) begin : g_trim
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				trim_reg[g] <= lfao_pkg::TRIM_RST;
			end else if (fuse_load) begin
				trim_reg[g] <= {4'h0, fuse_trim[g]};
			end else if (req.wr && trim_hit[g] && !trim_guard) begin
				trim_reg[g] <= req.wdata;
			end
		end
	end

	// applied trims; core two picks the trim of the sampled input
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core0_trim_reg <= lfao_pkg::TRIM_RST[11:0];
			core1_trim_reg <= lfao_pkg::TRIM_RST[11:0];
			core2_trim_reg <= lfao_pkg::TRIM_RST[11:0];
		end else begin
			core0_trim_reg <= trim_reg[lfao_pkg::TRIM_CORE0][11:0];
			core1_trim_reg <= trim_reg[lfao_pkg::TRIM_CORE1][11:0];
			core2_trim_reg <= core2_input_b_sel
				? trim_reg[lfao_pkg::TRIM_CORE2B][11:0]
				: trim_reg[lfao_pkg::TRIM_CORE2A][11:0];
		end
	end

	// interrupt events: new active lane fault, trim touched in a guard window
	assign irq_event[lfao_pkg::IRQ_FIFO_BIT]  = summary_set;
	assign irq_event[lfao_pkg::IRQ_GUARD_BIT] = trim_access && trim_guard;
	assign irq_clear = (req.wr && req.addr == lfao_pkg::IRQ_STATUS_ADDR)
		? req.wdata[1:0] : 2'h0;

	// sticky status, set wins over write-one clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status_reg <= lfao_pkg::IRQ_STATUS_RST;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_reg <= lfao_pkg::IRQ_MASK_RST;
		end else if (req.wr && req.addr == lfao_pkg::IRQ_MASK_ADDR) begin
			irq_mask_reg <= req.wdata[1:0];
		end
	end

	// level interrupt output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(((irq_status_reg & ~irq_clear) | irq_event) & irq_mask_reg);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = 16'h0000;
		unique case (req.addr)
			lfao_pkg::LANE_FLAGS_ADDR:  rdata_next = {8'h00, lane_fifo_error_flags_reg};
			lfao_pkg::SUMMARY_ADDR:
				rdata_next[lfao_pkg::SUMMARY_BIT] = fifo_error_summary_reg;
			lfao_pkg::CORE0_TRIM_ADDR:  rdata_next = trim_reg[lfao_pkg::TRIM_CORE0];
			lfao_pkg::CORE1_TRIM_ADDR:  rdata_next = trim_reg[lfao_pkg::TRIM_CORE1];
			lfao_pkg::CORE2A_TRIM_ADDR: rdata_next = trim_reg[lfao_pkg::TRIM_CORE2A];
			lfao_pkg::CORE2B_TRIM_ADDR: rdata_next = trim_reg[lfao_pkg::TRIM_CORE2B];
			lfao_pkg::IRQ_STATUS_ADDR:  rdata_next = {14'h0000, irq_status_reg};
			lfao_pkg::IRQ_MASK_ADDR:    rdata_next = {14'h0000, irq_mask_reg};
			default:                    rdata_next = 16'h0000;
		endcase
	end

	// read data stand for exactly the cycle after the read strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= req.rd ? rdata_next : 16'h0000;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_lane_w1c;
		req.wr && req.addr == lfao_pkg::LANE_FLAGS_ADDR;
	endsequence

	sequence s_summary_w1c;
		req.wr && req.addr == lfao_pkg::SUMMARY_ADDR && req.wdata[lfao_pkg::SUMMARY_BIT];
	endsequence

	a_lane_fault_sets: assert property (
		lane_fifo_fault != 8'h00 |=> (lane_fifo_error_flags_reg & $past(lane_fifo_fault))
			== $past(lane_fifo_fault))
		else $error("lane fault did not set its flag");

	a_lane_write_clear: assert property (
		s_lane_w1c ##0 (lane_fifo_fault == 8'h00) |=>
			(lane_fifo_error_flags_reg & $past(req.wdata[7:0])) == 8'h00)
		else $error("write one did not clear lane flag");

	a_lane_refire: assert property (
		s_lane_w1c ##0 (lane_fifo_fault != 8'h00) |=>
			(lane_fifo_error_flags_reg & $past(lane_fifo_fault)) == $past(lane_fifo_fault))
		else $error("persisting fault lost on clear");

	a_summary_clr_all: assert property (
		s_summary_w1c ##0 (lane_fifo_fault == 8'h00) |=> lane_fifo_error_flags_reg == 8'h00)
		else $error("summary clear left lane flags set");

	a_flags_hold: assert property (
		!$rose(reset_n) && lane_fifo_fault == 8'h00 && !req.wr
			|=> $stable(lane_fifo_error_flags_reg))
		else $error("lane flags changed without cause");

	a_trim_apply: assert property (
		req.wr && trim_hit[lfao_pkg::TRIM_CORE0] && !trim_guard && !fuse_load
			|=> ##1 core0_trim_reg == $past(req.wdata[11:0], 2))
		else $error("core0 trim write not applied");

	a_fuse_load: assert property (
		fuse_load |=> trim_reg[lfao_pkg::TRIM_CORE1] == {4'h0, $past(fuse_trim[1])})
		else $error("fuse value not loaded");

	a_core2_select: assert property (
		core2_input_b_sel |=> core2_trim_reg == $past(trim_reg[lfao_pkg::TRIM_CORE2B][11:0]))
		else $error("core2 uses wrong input trim");

	a_summary_sets: assert property (
		summary_set |=> fifo_error_summary_reg)
		else $error("active lane fault did not set summary");

	// reset values seen at release
	a_reset_flags: assert property (
		$rose(reset_n) |-> lane_fifo_error_flags_reg == lfao_pkg::LANE_FLAGS_RST)
		else $error("lane flags not all ones after reset");

	a_reset_summary: assert property (
		$rose(reset_n) |-> fifo_error_summary_reg == lfao_pkg::SUMMARY_RST)
		else $error("summary bit wrong after reset");

	a_summary_clear: assert property (
		s_summary_w1c ##0 !summary_set |=> !fifo_error_summary_reg)
		else $error("summary write one did not clear");

	a_summary_inactive: assert property (
		!fifo_error_summary_reg && !summary_set |=> !fifo_error_summary_reg)
		else $error("summary set without active lane fault");

	// trim guard window
	sequence s_trim_open_write;
		req.wr && trim_hit[lfao_pkg::TRIM_CORE0] && !trim_guard && !fuse_load;
	endsequence

	sequence s_trim_blocked_write;
		req.wr && trim_hit[lfao_pkg::TRIM_CORE0] && trim_guard && !fuse_load;
	endsequence

	a_trim_open_write: assert property (
		s_trim_open_write |=> trim_reg[lfao_pkg::TRIM_CORE0] == $past(req.wdata))
		else $error("open trim write not stored");

	a_guard_drops: assert property (
		s_trim_blocked_write |=> $stable(trim_reg[lfao_pkg::TRIM_CORE0]))
		else $error("guarded trim write was stored");

	a_guard_flags_irq: assert property (
		s_trim_blocked_write |=> irq_status_reg[lfao_pkg::IRQ_GUARD_BIT])
		else $error("guarded trim write not flagged");

	a_guard_busy: assert property (
		cal.cal_busy |-> trim_guard)
		else $error("busy calibration left trims open");

	a_guard_fg_wait: assert property (
		cal.offset_cal_en && !cal.foreground_cal_done |-> trim_guard)
		else $error("trims open before foreground done");

	a_guard_full_bg: assert property (
		cal.background_cal_en && cal.continuous_bg_offset_cal_en |-> trim_guard)
		else $error("trims open in continuous background");

	a_fuse_core0: assert property (
		fuse_load |=> trim_reg[lfao_pkg::TRIM_CORE0]
			== {4'h0, $past(fuse_trim[lfao_pkg::TRIM_CORE0])})
		else $error("core0 fuse value not loaded");

	// applied trims and read port
	a_core1_apply: assert property (
		1'b1 |=> core1_trim_reg == $past(trim_reg[lfao_pkg::TRIM_CORE1][11:0]))
		else $error("core1 applied trim lags wrongly");

	a_core2_input_a: assert property (
		!core2_input_b_sel |=> core2_trim_reg == $past(trim_reg[lfao_pkg::TRIM_CORE2A][11:0]))
		else $error("core2 uses wrong input a trim");

	a_rdata_idle: assert property (
		!req.rd |=> rdata_reg == 16'h0000)
		else $error("read data not zero outside answer");

	a_rdata_flags: assert property (
		req.rd && req.addr == lfao_pkg::LANE_FLAGS_ADDR
			|=> rdata_reg == {8'h00, $past(lane_fifo_error_flags_reg)})
		else $error("lane flag read data wrong");

	// interrupt status and level
	a_irq_level: assert property (
		(irq_status_reg & irq_mask_reg) != 2'h0 && irq_clear == 2'h0 |=> irq_reg)
		else $error("unmasked status left irq low");

	a_irq_quiet: assert property (
		((irq_status_reg | irq_event) & irq_mask_reg) == 2'h0 |=> !irq_reg)
		else $error("irq high without unmasked status");

	a_event_wins: assert property (
		irq_event[lfao_pkg::IRQ_FIFO_BIT] |=> irq_status_reg[lfao_pkg::IRQ_FIFO_BIT])
		else $error("fault event lost in status");

endmodule : lfao_regs

//--- dv/lfao_regs_bench.sv
/*
 * lfao_regs_bench: self-checking bench for the lane fifo alarm and trim bank.
 * assumes lfao_pkg is compiled first and the bank answers reads one cycle later.
 */
`timescale 1ns/1ps
module lfao_regs_bench;
	logic                     clk;
	logic                     reset_n;
	lfao_pkg::lfao_req_t      req;
	logic [15:0]              rdata_reg;
	logic [7:0]               lane_fifo_fault;
	logic [7:0]               lane_active;
	lfao_pkg::lfao_cal_t      cal;
	logic                     fuse_load;
	lfao_pkg::lfao_trim_set_t fuse_trim;
	logic                     core2_input_b_sel;
	logic [11:0]              core0_trim_reg;
	logic [11:0]              core1_trim_reg;
	logic [11:0]              core2_trim_reg;
	logic                     fifo_error_summary_reg;
	logic                     irq_reg;
	logic [15:0]              q;
	int                       n_errors;
	int                       checks_done;
	logic [4:0]               guard_cfg [3] = '{5'b00001, 5'b01100, 5'b10000};

	// device under test
	lfao_regs dut_u (.clk, .reset_n, .req, .rdata_reg, .lane_fifo_fault, .lane_active,
		.cal, .fuse_load, .fuse_trim, .core2_input_b_sel, .core0_trim_reg,
		.core1_trim_reg, .core2_trim_reg, .fifo_error_summary_reg, .irq_reg);

	// free running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// compare and count
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one bus cycle, read data captured in the answer cycle
	task bus(input logic [11:0] a, input logic [15:0] d, input logic w);
		@(posedge clk);
		req <= '{a, d, w, !w};
		@(posedge clk);
		req <= '{a, d, 1'b0, 1'b0};
		#1;
		q = rdata_reg;
	endtask : bus

	task rd_chk(input logic [11:0] a, input logic [15:0] e);
		bus(a, 16'h0000, 1'b0);
		chk(q, e);
	endtask : rd_chk

	// one-cycle fault pulse on the chosen lanes
	task pulse(input logic [7:0] f);
		@(posedge clk);
		lane_fifo_fault <= f;
		@(posedge clk);
		lane_fifo_fault <= 8'h00;
	endtask : pulse

	task t_reset;
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h00FF);
		rd_chk(lfao_pkg::SUMMARY_ADDR, 16'h0020);
		rd_chk(lfao_pkg::CORE0_TRIM_ADDR, 16'h0000);
		chk(16'(irq_reg), 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task t_lanes;
		bus(lfao_pkg::LANE_FLAGS_ADDR, 16'h00FE, 1'b1);
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h0001);
		bus(lfao_pkg::LANE_FLAGS_ADDR, 16'h0001, 1'b1);
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'(8'h01 << i));
			bus(lfao_pkg::LANE_FLAGS_ADDR, 16'(8'h01 << i), 1'b1);
		end
		// fault held across the clearing write
		@(posedge clk);
		lane_fifo_fault <= 8'h04;
		bus(lfao_pkg::LANE_FLAGS_ADDR, 16'h0004, 1'b1);
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h0004);
		@(posedge clk);
		lane_fifo_fault <= 8'h00;
		bus(lfao_pkg::LANE_FLAGS_ADDR, 16'h0004, 1'b1);
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h0000);
		$display("test lanes done");
	endtask : t_lanes

	task t_summary;
		pulse(8'hA5);
		bus(lfao_pkg::SUMMARY_ADDR, 16'h0020, 1'b1);
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h0000);
		rd_chk(lfao_pkg::SUMMARY_ADDR, 16'h0000);
		@(posedge clk);
		lane_active <= 8'hFE;
		pulse(8'h01);
		rd_chk(lfao_pkg::LANE_FLAGS_ADDR, 16'h0001);
		chk(16'(fifo_error_summary_reg), 16'h0000);
		pulse(8'h02);
		rd_chk(lfao_pkg::SUMMARY_ADDR, 16'h0020);
		chk(16'(fifo_error_summary_reg), 16'h0001);
		@(posedge clk);
		lane_active <= 8'hFF;
		bus(lfao_pkg::SUMMARY_ADDR, 16'h0020, 1'b1);
		$display("test summary done");
	endtask : t_summary

	task t_irq;
		rd_chk(lfao_pkg::IRQ_STATUS_ADDR, 16'h0001);
		chk(16'(irq_reg), 16'h0000);
		bus(lfao_pkg::IRQ_MASK_ADDR, 16'h0003, 1'b1);
		@(posedge clk);
		#1;
		chk(16'(irq_reg), 16'h0001);
		bus(lfao_pkg::IRQ_STATUS_ADDR, 16'h0001, 1'b1);
		@(posedge clk);
		#1;
		chk(16'(irq_reg), 16'h0000);
		rd_chk(12'h100, 16'h0000);
		$display("test irq done");
	endtask : t_irq

	task t_fuse;
		@(posedge clk);
		fuse_trim <= {12'hDDD, 12'hCCC, 12'hBBB, 12'hAAA};
		fuse_load <= 1'b1;
		@(posedge clk);
		fuse_load <= 1'b0;
		rd_chk(lfao_pkg::CORE0_TRIM_ADDR, 16'h0AAA);
		rd_chk(lfao_pkg::CORE1_TRIM_ADDR, 16'h0BBB);
		rd_chk(lfao_pkg::CORE2A_TRIM_ADDR, 16'h0CCC);
		rd_chk(lfao_pkg::CORE2B_TRIM_ADDR, 16'h0DDD);
		chk(16'(core0_trim_reg), 16'h0AAA);
		chk(16'(core1_trim_reg), 16'h0BBB);
		chk(16'(core2_trim_reg), 16'h0CCC);
		@(posedge clk);
		core2_input_b_sel <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(16'(core2_trim_reg), 16'h0DDD);
		$display("test fuse done");
	endtask : t_fuse

	task t_guard;
		bus(lfao_pkg::CORE0_TRIM_ADDR, 16'h0123, 1'b1);
		rd_chk(lfao_pkg::CORE0_TRIM_ADDR, 16'h0123);
		chk(16'(core0_trim_reg), 16'h0123);
		// each blocked calibration setup drops the write and flags it
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			cal <= guard_cfg[i];
			bus(lfao_pkg::CORE0_TRIM_ADDR, 16'h0456, 1'b1);
			rd_chk(lfao_pkg::CORE0_TRIM_ADDR, 16'h0123);
			@(posedge clk);
			cal <= 5'b00000;
			rd_chk(lfao_pkg::IRQ_STATUS_ADDR, 16'h0002);
			bus(lfao_pkg::IRQ_STATUS_ADDR, 16'h0002, 1'b1);
		end
		@(posedge clk);
		cal <= 5'b10010;
		bus(lfao_pkg::CORE0_TRIM_ADDR, 16'h0789, 1'b1);
		rd_chk(lfao_pkg::CORE0_TRIM_ADDR, 16'h0789);
		@(posedge clk);
		cal <= 5'b11010;
		bus(lfao_pkg::CORE0_TRIM_ADDR, 16'h0321, 1'b1);
		rd_chk(lfao_pkg::CORE0_TRIM_ADDR, 16'h0321);
		rd_chk(lfao_pkg::IRQ_STATUS_ADDR, 16'h0000);
		$display("test guard done");
	endtask : t_guard

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		final_report();
	end

	// main sequence
	initial begin
		n_errors = 0;
		checks_done = 0;
		reset_n = 1'b0;
		req = '0;
		lane_fifo_fault = 8'h00;
		lane_active = 8'hFF;
		cal = '0;
		fuse_load = 1'b0;
		fuse_trim = '0;
		core2_input_b_sel = 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_lanes();
		t_summary();
		t_irq();
		t_fuse();
		t_guard();
		final_report();
	end
endmodule : lfao_regs_bench
